// ==== logic/adc_seq.sv ====
/*
  Sampling trigger and conversion mode sequencer of a 12-bit serial ADC.
  Decides when sampling starts and ends, which trigger starts a
  conversion, and how the four conversion modes use the result FIFO,
  the interrupt and the end-of-conversion indication.
  Assumes all pins are synchronous to mclk_i, that the serial shifter
  pulses cmd_valid_i once the first four command bits are in, and that
  the configuration fields come from a register held elsewhere.
*/
// Overview of operation
// - Conversion command starts the sampling period
// - Normal sampling lasts 12 or 24 serial clocks
// - Pin falling edge with select high samples
// - Pin rising edge ends sampling, starts conversion
// - Repeat select: sampling waits for select high
// - Two select falls, pin high, leave extended
// - Buffered result shown on next read cycle
// - Pin trigger in modes 01-11 needs internal reference
// - Conversion lasts 14 times divider serial clocks
// - Select or sync trigger: 16 or 28 clocks
// - Any command still acts, e.g. power down
// - Mode 00 bypasses FIFO, end flag or interrupt
// - Mode 01 fills FIFO; unread data lost later
// - Repeat pin: early sample converts after 2 us
// - Mode 10 sweeps channels into FIFO to threshold
// - Mode 10 waits for FIFO read before sweeping
// - Mode 11 threshold interrupt, read keeps order
// - Mode 11 without read clears FIFO, continues
// - Mode field encodes 00, 01, 10, 11
// - Clock source field: oscillator, SCLK, /4, /2
// - Trigger level field sets threshold and sweep length
// - Sample select bit: 12 or 24 clocks
`timescale 1ns/1ps
`include "adc_seq_cfg.svh"
module adc_seq
  import adc_seq_pkg::*;
#(
  parameter int DATA_W = 12,
  parameter int DEPTH  = 8,
  parameter int AW     = 3
)
(
  input  wire logic              mclk_i,
  input  wire logic              rst_n_i,
  input  wire logic              ce_i,
  input  wire logic              sclk_i,
  input  wire logic              cs_n_i,
  input  wire logic              frame_sync_pin_i,
  input  wire logic              conv_start_pin_n_i,
  input  wire logic              osc_tick_i,
  input  wire logic              cmd_valid_i,
  input  wire logic [3:0]        cmd_i,
  input  wire logic              rd_pop_i,
  input  wire logic [DATA_W-1:0] conv_data_i,
  input  wire logic              ref_internal_i,
  input  wire logic              long_sample_i,
  input  wire field2_t           clk_src_i,
  input  wire field2_t           mode_i,
  input  wire field2_t           sweep_seq_i,
  input  wire logic              eoc_pin_sel_i,
  input  wire field2_t           fifo_level_i,
  output logic                   sampling_o,
  output logic                   converting_o,
  output logic                   eoc_busy_o,
  output logic                   int_o,
  output logic                   extended_o,
  output logic                   power_down_o,
  output logic [3:0]             channel_o,
  output logic [DATA_W-1:0]      data_out_o,
  output logic                   data_valid_o,
  output logic [AW:0]            fifo_count_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Channel select or self-test select
  function automatic logic is_conv_cmd(input logic [3:0] cmd);
    is_conv_cmd = (cmd <= `CMD_CH_LAST) ||
                  ((cmd >= `CMD_TEST_FIRST) && (cmd <= `CMD_TEST_LAST));
  endfunction

  // Channel for a sweep position
  function automatic logic [3:0] sweep_channel(input field2_t seq, input logic [2:0] idx);
    case (seq)
      `SEQ_ALL:   sweep_channel = {1'b0, idx};
      `SEQ_EVEN:  sweep_channel = {1'b0, idx[1:0], 1'b0};
      `SEQ_PAIRS: sweep_channel = {1'b0, idx[2:1], 1'b0};
      default:    sweep_channel = {2'h0, idx[0], 1'b0};
    endcase
  endfunction

  // Entries that make the threshold: highest filled level plus one
  function automatic logic [AW:0] fifo_thr(input field2_t lvl);
    case (lvl)
      `LVL_FULL: fifo_thr = (AW+1)'(`FIFO_LVL_FULL + 4'h1);
      `LVL_3Q:   fifo_thr = (AW+1)'(`FIFO_LVL_3Q + 4'h1);
      `LVL_HALF: fifo_thr = (AW+1)'(`FIFO_LVL_HALF + 4'h1);
      default:   fifo_thr = (AW+1)'(`FIFO_LVL_1Q + 4'h1);
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  seq_state_e        state_reg;
  logic              sclk_q_reg;
  logic              cs_q_reg;
  logic              fs_q_reg;
  logic              pin_q_reg;
  logic [4:0]        cnt_reg;
  logic              pin_mode_reg;
  logic              early_reg;
  logic              early_conv_reg;
  logic [8:0]        timer_reg;
  logic              ext_reg;
  logic              exit_cnt_reg;
  logic [2:0]        sweep_idx_reg;
  logic              sweep_hold_reg;
  logic [AW-1:0]     wr_ptr_reg;
  logic [AW-1:0]     rd_ptr_reg;
  logic [AW:0]       count_reg;
  logic              read_active_reg;
  logic              thr_hit_reg;
  logic              pend_clear_reg;
  logic [DATA_W-1:0] out_buf_reg;
  logic              buf_valid_reg;
  logic [DATA_W-1:0] mem_rd_data;
  logic              conv_tick;
  logic [AW:0]       count_next;

  logic sclk_rise;
  logic cs_fall;
  logic fs_fall;
  logic pin_fall;
  logic pin_rise;
  logic cycle_start;
  logic pin_enabled;
  logic pin_trig;
  logic conv_cmd;
  logic fifo_rd_cmd;
  logic sweep_mode;
  logic conv_done;
  logic store;
  logic pop;
  logic read_end;
  logic base_clr;
  logic thr_reached;
  logic [4:0] sample_last;

  ////////////////////////////////////////////////////////////////////////////
  // Pin edges and triggers

  // Previous pin levels for edge detection
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      sclk_q_reg <= 1'b0;
      cs_q_reg   <= 1'b1;
      fs_q_reg   <= 1'b1;
      pin_q_reg  <= 1'b1;
    end
    else if (ce_i)
    begin
      sclk_q_reg <= sclk_i;
      cs_q_reg   <= cs_n_i;
      fs_q_reg   <= frame_sync_pin_i;
      pin_q_reg  <= conv_start_pin_n_i;
    end
  end

  assign sclk_rise   = sclk_i && !sclk_q_reg;
  assign cs_fall     = !cs_n_i && cs_q_reg;
  assign fs_fall     = !frame_sync_pin_i && fs_q_reg;
  assign pin_fall    = !conv_start_pin_n_i && pin_q_reg;
  assign pin_rise    = conv_start_pin_n_i && !pin_q_reg;
  // Sync held high: select fall starts a cycle; else the sync fall does
  assign cycle_start = (cs_fall && frame_sync_pin_i) || fs_fall;
  assign pin_enabled = (mode_i == `MODE_ONE_SHOT) || ref_internal_i;
  assign pin_trig    = pin_fall && cs_n_i && pin_enabled;
  assign conv_cmd    = cmd_valid_i && is_conv_cmd(cmd_i);
  assign fifo_rd_cmd = cmd_valid_i && (cmd_i == `CMD_FIFO_READ);
  assign sweep_mode  = mode_i[1];
  assign sample_last = (long_sample_i ? `LONG_SAMPLE_SCLKS : `SHORT_SAMPLE_SCLKS) - 5'h01;
  assign conv_done   = (state_reg == ST_CONVERT) && conv_tick && (cnt_reg == `CONV_TICKS - 5'h01);

  ////////////////////////////////////////////////////////////////////////////
  // Extended sampling flag

  // Entered by a pin trigger; two select falls with pin high leave it
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      ext_reg      <= 1'b0;
      exit_cnt_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      if (pin_trig)
      begin
        ext_reg      <= 1'b1;
        exit_cnt_reg <= 1'b0;
      end
      else if (ext_reg && cs_fall && conv_start_pin_n_i)
      begin
        ext_reg      <= !exit_cnt_reg;
        exit_cnt_reg <= !exit_cnt_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample and convert sequencer

  // A pin edge during conversion is not seen; host spacing covers it
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      state_reg      <= ST_IDLE;
      cnt_reg        <= 5'h00;
      pin_mode_reg   <= 1'b0;
      early_reg      <= 1'b0;
      early_conv_reg <= 1'b0;
      timer_reg      <= 9'h000;
      channel_o      <= 4'h0;
    end
    else if (ce_i)
    begin
      case (state_reg)
        ST_IDLE:
        begin
          cnt_reg <= 5'h00;
          if (conv_cmd && !sweep_hold_reg)
          begin
            channel_o <= sweep_mode ? sweep_channel(sweep_seq_i, sweep_idx_reg) : cmd_i;
            if (ext_reg && (mode_i == `MODE_REPEAT))
            begin
              state_reg <= ST_WAIT_CS;
            end
            else if (!ext_reg)
            begin
              state_reg    <= ST_SAMPLE;
              pin_mode_reg <= 1'b0;
            end
          end
          else if (pin_trig && !sweep_hold_reg)
          begin
            if (sweep_mode)
            begin
              channel_o <= sweep_channel(sweep_seq_i, sweep_idx_reg);
            end
            state_reg    <= ST_SAMPLE;
            pin_mode_reg <= 1'b1;
            early_reg    <= 1'b0;
          end
        end
        ST_WAIT_CS:
        begin
          if (cs_n_i)
          begin
            state_reg    <= ST_SAMPLE;
            pin_mode_reg <= 1'b1;
            early_reg    <= 1'b1;
            timer_reg    <= 9'h000;
          end
        end
        ST_SAMPLE:
        begin
          if (early_reg && (timer_reg != `EARLY_CONV_CYCLES))
          begin
            timer_reg <= timer_reg + 9'h001;
          end
          if (pin_mode_reg)
          begin
            if (pin_rise)
            begin
              state_reg <= ST_CONVERT;
              early_reg <= 1'b0;
            end
            else if (early_reg && pin_fall)
            begin
              early_reg <= 1'b0;
              if (timer_reg == `EARLY_CONV_CYCLES)
              begin
                state_reg      <= ST_CONVERT;
                early_conv_reg <= 1'b1;
              end
            end
          end
          else if (sclk_rise)
          begin
            if (cnt_reg == sample_last)
            begin
              state_reg <= ST_CONVERT;
              cnt_reg   <= 5'h00;
            end
            else
            begin
              cnt_reg <= cnt_reg + 5'h01;
            end
          end
        end
        ST_CONVERT:
        begin
          if (conv_tick)
          begin
            cnt_reg <= cnt_reg + 5'h01;
          end
          if (conv_done)
          begin
            cnt_reg        <= 5'h00;
            early_conv_reg <= 1'b0;
            // Pin fell during the early sample: that fall opened a sample
            if (early_conv_reg && !conv_start_pin_n_i)
            begin
              state_reg    <= ST_SAMPLE;
              pin_mode_reg <= 1'b1;
            end
            else
            begin
              state_reg <= ST_IDLE;
            end
            if (sweep_mode)
            begin
              channel_o <= sweep_channel(sweep_seq_i, sweep_idx_reg + 3'h1);
            end
          end
        end
        default:
        begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result FIFO control

  assign store       = conv_done && (mode_i != `MODE_ONE_SHOT);
  assign pop         = read_active_reg && rd_pop_i && (count_reg != '0);
  assign read_end    = read_active_reg && (cycle_start || (pop && (count_reg == (AW+1)'(1))));
  assign base_clr    = read_end ||
                       (store && (pend_clear_reg || (count_reg == (AW+1)'(DEPTH))));
  assign count_next  = base_clr ? (AW+1)'(store) : count_reg + (AW+1)'(store) - (AW+1)'(pop);
  assign thr_reached = store && (count_next == fifo_thr(fifo_level_i));

  // Pointers and fill counter; a clear restarts them at zero, the write pointer and counter at one when a result is stored in the same cycle
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else if (ce_i)
    begin
      count_reg <= count_next;
      if (base_clr)
      begin
        rd_ptr_reg <= '0;
        wr_ptr_reg <= store ? AW'(1) : '0;
      end
      else
      begin
        wr_ptr_reg <= wr_ptr_reg + AW'(store);
        rd_ptr_reg <= rd_ptr_reg + AW'(pop);
      end
    end
  end

  // Read cycle, threshold and pending clear; sets win over clears
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      read_active_reg <= 1'b0;
      thr_hit_reg     <= 1'b0;
      pend_clear_reg  <= 1'b0;
      sweep_hold_reg  <= 1'b0;
      sweep_idx_reg   <= 3'h0;
    end
    else if (ce_i)
    begin
      if (fifo_rd_cmd && (mode_i != `MODE_ONE_SHOT))
        read_active_reg <= 1'b1;
      else if (read_end)
        read_active_reg <= 1'b0;
      if (thr_reached)
        thr_hit_reg <= 1'b1;
      else if (fifo_rd_cmd || base_clr)
        thr_hit_reg <= 1'b0;
      if (thr_hit_reg && mode_i[0] && ((cmd_valid_i && !fifo_rd_cmd) || pin_fall))
        pend_clear_reg <= 1'b1;
      else if (base_clr)
        pend_clear_reg <= 1'b0;
      if (thr_reached && (mode_i == `MODE_SWEEP))
        sweep_hold_reg <= 1'b1;
      else if (read_end)
        sweep_hold_reg <= 1'b0;
      if (read_end || (base_clr && !store) || (thr_reached && sweep_mode))
        sweep_idx_reg <= 3'h0;
      else if (conv_done && sweep_mode)
        sweep_idx_reg <= sweep_idx_reg + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output buffer, data out and indications

  // One-shot results bypass the FIFO into the output buffer
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      out_buf_reg   <= '0;
      buf_valid_reg <= 1'b0;
      data_out_o    <= '0;
      data_valid_o  <= 1'b0;
    end
    else if (ce_i)
    begin
      if (conv_done && (mode_i == `MODE_ONE_SHOT))
      begin
        out_buf_reg   <= conv_data_i;
        buf_valid_reg <= 1'b1;
      end
      else if (cmd_valid_i && (fifo_rd_cmd || conv_cmd) && buf_valid_reg)
      begin
        buf_valid_reg <= 1'b0;
      end
      if (read_active_reg)
      begin
        data_out_o   <= mem_rd_data;
        data_valid_o <= (count_reg != '0);
      end
      else if (cmd_valid_i && (fifo_rd_cmd || conv_cmd) && buf_valid_reg)
      begin
        data_out_o   <= out_buf_reg;
        data_valid_o <= 1'b1;
      end
      else if (cycle_start)
      begin
        data_valid_o <= 1'b0;
      end
    end
  end

  // Registered status; state flags lag the sequencer by one cycle, fifo_count_o does not
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      sampling_o   <= 1'b0;
      converting_o <= 1'b0;
      eoc_busy_o   <= 1'b0;
      int_o        <= 1'b0;
      extended_o   <= 1'b0;
      power_down_o <= 1'b0;
      fifo_count_o <= '0;
    end
    else if (ce_i)
    begin
      sampling_o   <= (state_reg == ST_SAMPLE);
      converting_o <= (state_reg == ST_CONVERT);
      eoc_busy_o   <= (state_reg == ST_CONVERT) && !conv_done && eoc_pin_sel_i &&
                      (mode_i == `MODE_ONE_SHOT);
      extended_o   <= ext_reg;
      fifo_count_o <= count_next;
      if ((conv_done && (mode_i == `MODE_ONE_SHOT) && !eoc_pin_sel_i) || thr_reached)
        int_o <= 1'b1;
      else if (cycle_start || cmd_valid_i)
        int_o <= 1'b0;
      if (cmd_valid_i && (cmd_i == `CMD_PWR_DOWN))
        power_down_o <= 1'b1;
      else if (conv_cmd)
        power_down_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instances

  conv_clock_div i_conv_clock_div (
    .mclk_i      (mclk_i),
    .rst_n_i     (rst_n_i),
    .ce_i        (ce_i),
    .src_i       (clk_src_i),
    .sclk_rise_i (sclk_rise),
    .osc_tick_i  (osc_tick_i),
    .restart_i   (state_reg != ST_CONVERT),
    .tick_o      (conv_tick)
  );

  fifo_mem #(
    .WIDTH (DATA_W),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) i_fifo_mem (
    .mclk_i    (mclk_i),
    .ce_i      (ce_i),
    .wr_en_i   (store),
    .wr_addr_i (base_clr ? AW'(0) : wr_ptr_reg),
    .wr_data_i (conv_data_i),
    .rd_addr_i (rd_ptr_reg),
    .rd_data_o (mem_rd_data)
  );

endmodule

// ==== logic/adc_seq_cfg.svh ====
/*
  Constants of the sampling and conversion sequencer: command codes,
  configuration field encodings, sample and conversion lengths, timing.
  Assumes it is included by bare name from the design files.
*/
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH

// Command codes, first four serial bits
`define CMD_CH_LAST      4'h7
`define CMD_PWR_DOWN     4'h8
`define CMD_TEST_FIRST   4'hB
`define CMD_TEST_LAST    4'hD
`define CMD_FIFO_READ    4'hE

// Conversion mode field
`define MODE_ONE_SHOT    2'h0
`define MODE_REPEAT      2'h1
`define MODE_SWEEP       2'h2
`define MODE_REP_SWEEP   2'h3

// Conversion clock source field
`define CLK_OSC          2'h0
`define CLK_SCLK         2'h1
`define CLK_SCLK_DIV4    2'h2
`define CLK_SCLK_DIV2    2'h3
`define PRE_LAST_DIV4    2'h3
`define PRE_LAST_DIV2    2'h1
`define PRE_LAST_DIV1    2'h0

// FIFO trigger level field and the highest level that must fill
`define LVL_FULL         2'h0
`define LVL_3Q           2'h1
`define LVL_HALF         2'h2
`define LVL_1Q           2'h3
`define FIFO_LVL_FULL    4'h7
`define FIFO_LVL_3Q      4'h5
`define FIFO_LVL_HALF    4'h3
`define FIFO_LVL_1Q      4'h1

// Sweep sequence field
`define SEQ_ALL          2'h0
`define SEQ_EVEN         2'h1
`define SEQ_PAIRS        2'h2
`define SEQ_ZERO_TWO     2'h3

// Serial clock counts
`define SHORT_SAMPLE_SCLKS 5'h0C
`define LONG_SAMPLE_SCLKS  5'h18
`define CONV_TICKS         5'h0E

// Least time left after the select cycle for the first sample to convert
`define CLK_PERIOD_NS    8
`define EARLY_CONV_NS    2000
`define EARLY_CONV_CYCLES (9'((`EARLY_CONV_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))

`endif

// ==== logic/adc_seq_pkg.sv ====
/*
  Types shared by the sequencer files.
  Assumes nothing of its surroundings.
*/
package adc_seq_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_CS,
    ST_SAMPLE,
    ST_CONVERT
  } seq_state_e;

  typedef logic [1:0] field2_t;

endpackage

// ==== logic/fifo_mem.sv ====
/*
  Small result memory: one write port, one read port, read data registered.
  Assumes a single clock and that the caller manages pointers.
*/
`timescale 1ns/1ps
module fifo_mem
  import adc_seq_pkg::*;
#(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8,
  parameter int AW    = 3
)
(
  input  wire logic             mclk_i,
  input  wire logic             ce_i,
  input  wire logic             wr_en_i,
  input  wire logic [AW-1:0]    wr_addr_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  input  wire logic [AW-1:0]    rd_addr_i,
  output logic      [WIDTH-1:0] rd_data_o
);

  logic [WIDTH-1:0] mem_reg [DEPTH];

  // Storage and registered read; no reset, contents are guarded by count
  always_ff @(posedge mclk_i)
  begin
    if (ce_i)
    begin
      if (wr_en_i)
      begin
        mem_reg[wr_addr_i] <= wr_data_i;
      end
      rd_data_o <= mem_reg[rd_addr_i];
    end
  end

endmodule

// ==== logic/conv_clock_div.sv ====
/*
  Conversion clock tick: internal oscillator tick, or serial clock edges
  divided by one, two or four.
  Assumes serial clock edges arrive as one-cycle pulses in the mclk domain.
*/
`timescale 1ns/1ps
`include "adc_seq_cfg.svh"
module conv_clock_div
  import adc_seq_pkg::*;
(
  input  wire logic    mclk_i,
  input  wire logic    rst_n_i,
  input  wire logic    ce_i,
  input  wire field2_t src_i,
  input  wire logic    sclk_rise_i,
  input  wire logic    osc_tick_i,
  input  wire logic    restart_i,
  output logic         tick_o
);

  logic [1:0] pre_reg;
  logic [1:0] pre_last;

  // Prescaler wrap point from the source field
  always_comb
  begin
    case (src_i)
      `CLK_SCLK_DIV4: pre_last = `PRE_LAST_DIV4;
      `CLK_SCLK_DIV2: pre_last = `PRE_LAST_DIV2;
      default:        pre_last = `PRE_LAST_DIV1;
    endcase
  end

  // Prescaler restarts so every conversion has full-length ticks
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      pre_reg <= 2'h0;
    end
    else if (ce_i)
    begin
      if (restart_i)
      begin
        pre_reg <= 2'h0;
      end
      else if (sclk_rise_i)
      begin
        pre_reg <= (pre_reg == pre_last) ? 2'h0 : pre_reg + 2'h1;
      end
    end
  end

  // One tick per conversion clock period
  assign tick_o = (src_i == `CLK_OSC) ? osc_tick_i
                                      : (sclk_rise_i && (pre_reg == pre_last));

endmodule

// ==== dv/host_port.sv ====
/* Host serial port model: one frame while run_i is high.
   Assumes the bench holds run_i for a whole frame. */
`timescale 1ns/1ps
module host_port
(
  input  wire logic mclk_i,
  input  wire logic run_i,
  input  wire logic keep_cs_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      fs_o,
  output logic      cmd_valid_o
);
  logic [7:0] cnt_reg;
  // Clock stands still between frames; one command per frame
  always_ff @(posedge mclk_i)
  begin
    cnt_reg     <= run_i ? cnt_reg + 8'h01 : 8'h00;
    sclk_o      <= run_i & cnt_reg[1];
    cs_n_o      <= ~(run_i | keep_cs_i); // Select may stay low under frame sync
    fs_o        <= ~(run_i & (cnt_reg == 8'h00));
    cmd_valid_o <= run_i & (cnt_reg == 8'h0F);
  end
endmodule

// ==== dv/adc_seq_asserts.sv ====
/* Port assertions of the sequencer.
   Assumes the fields stay steady during an operation. */
`timescale 1ns/1ps
module adc_seq_asserts
  import adc_seq_pkg::*;
#(
  parameter int AW = 3
)
(
  input wire logic        mclk_i,
  input wire logic        rst_n_i,
  input wire logic        cs_n_i,
  input wire logic        cmd_valid_i,
  input wire logic [3:0]  cmd_i,
  input wire logic        conv_start_pin_n_i,
  input wire field2_t     mode_i,
  input wire logic        eoc_pin_sel_i,
  input wire logic        sampling_o,
  input wire logic        converting_o,
  input wire logic        eoc_busy_o,
  input wire logic        extended_o,
  input wire logic        power_down_o,
  input wire logic [AW:0] fifo_count_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // Idle means none of the three status flags is up; a held sweep refuses commands
  property p_start;
    cmd_valid_i && cmd_i < 4'h8 && !sampling_o && !converting_o && !extended_o
      && !(mode_i == 2'h2 && fifo_count_o != '0)
      |-> ##[1:3] sampling_o;
  endproperty
  a_start: assert property (p_start) else $error("no sampling");
  property p_samp;
    $rose(sampling_o) && !extended_o |-> sampling_o[*8];
  endproperty
  a_samp: assert property (p_samp) else $error("sampling short");
  property p_pin_fall;
    $fell(conv_start_pin_n_i) && cs_n_i && mode_i == 2'h0 && !sampling_o && !converting_o
      |-> ##[1:3] (sampling_o && extended_o);
  endproperty
  a_pin_fall: assert property (p_pin_fall) else $error("no pin sampling");
  property p_pin_rise;
    extended_o && sampling_o && $rose(conv_start_pin_n_i) |-> ##[1:3] converting_o;
  endproperty
  a_pin_rise: assert property (p_pin_rise) else $error("no pin conversion");
  property p_conv;
    $rose(converting_o) |-> converting_o[*8];
  endproperty
  a_conv: assert property (p_conv) else $error("conversion short");
  property p_eoc;
    eoc_busy_o |-> mode_i == 2'h0 && eoc_pin_sel_i;
  endproperty
  a_eoc: assert property (p_eoc) else $error("busy flag misused");
  property p_pd;
    cmd_valid_i && cmd_i == 4'h8 |-> ##[1:2] power_down_o;
  endproperty
  a_pd: assert property (p_pd) else $error("no power down");
  // Fill count steps by one either way or restarts after a clear
  property p_count;
    fifo_count_o != $past(fifo_count_o)
      |-> fifo_count_o <= 1 || fifo_count_o == $past(fifo_count_o) + 1'b1 ||
          fifo_count_o == $past(fifo_count_o) - 1'b1;
  endproperty
  a_count: assert property (p_count) else $error("count jump");
endmodule
bind adc_seq adc_seq_asserts #(.AW(AW)) i_adc_seq_asserts(.mclk_i, .rst_n_i, .cs_n_i,
  .cmd_valid_i, .cmd_i, .conv_start_pin_n_i, .mode_i, .eoc_pin_sel_i, .sampling_o,
  .converting_o, .eoc_busy_o, .extended_o, .power_down_o, .fifo_count_o);

// ==== dv/test_adc_seq.sv ====
/* Self-checking bench of the sequencer with a host port model.
   Assumes the oscillator ticks every other cycle. */
`timescale 1ns/1ps
module test_adc_seq;
  logic mclk, rst_n, osc, run, pin_n, ref_int, long_s, eoc_sel, e;
  logic sclk, cs_n, cmd_v, samp, conv, eoc, intr, ext, pd, dv, keep, fs;
  logic [11:0] dout;
  logic [3:0] code, ch, cnt;
  logic [1:0] mode, lvl, src;
  int err_total = 0, n_compared = 0, s, c;
  host_port i_host_port(.mclk_i(mclk), .run_i(run), .keep_cs_i(keep), .sclk_o(sclk),
    .cs_n_o(cs_n), .fs_o(fs), .cmd_valid_o(cmd_v));
  adc_seq i_adc_seq(.mclk_i(mclk), .rst_n_i(rst_n), .ce_i(1'b1), .sclk_i(sclk), .cs_n_i(cs_n),
    .frame_sync_pin_i(fs), .conv_start_pin_n_i(pin_n), .osc_tick_i(osc), .cmd_valid_i(cmd_v),
    .cmd_i(code), .rd_pop_i(1'b0), .conv_data_i(12'h0A5C), .ref_internal_i(ref_int),
    .long_sample_i(long_s), .clk_src_i(src), .mode_i(mode), .sweep_seq_i(2'h0),
    .eoc_pin_sel_i(eoc_sel), .fifo_level_i(lvl), .sampling_o(samp), .converting_o(conv),
    .eoc_busy_o(eoc), .int_o(intr), .extended_o(ext), .power_down_o(pd), .channel_o(ch),
    .data_out_o(dout), .data_valid_o(dv), .fifo_count_o(cnt));
  initial
  begin
    mclk = 0;
    forever #4 mclk = ~mclk;
  end
  always @(negedge mclk) osc <= rst_n & ~osc;
  task automatic chk(input bit ok, input string m);
    n_compared++;
    if (!ok)
    begin
      err_total++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // One frame: measure sampling and conversion lengths in cycles
  task automatic conv_once(input logic [3:0] k);
    code = k;
    run = 1;
    for (int w = 0; w < 200 && !samp; w++) @(negedge mclk);
    for (s = 0; samp && s < 400; s++) @(negedge mclk);
    e = eoc;
    for (c = 0; conv && c < 400; c++) @(negedge mclk);
    repeat (4) @(negedge mclk);
    run = 0;
    repeat (4) @(negedge mclk);
  endtask
  task automatic t_normal;
    for (int k = 0; k < 4; k++)
    begin
      long_s = k[0];
      src = {1'b0, k[1]};
      conv_once(4'h3);
      chk(s > 40 + 48 * k[0] && s < 56 + 48 * k[0], "sample length");
      chk(c > 22 + 28 * k[1] && c < 34 + 28 * k[1], "conversion length");
      chk(ch === 4'h3 && e === 1'b1, "channel or busy");
    end
    $display("normal done");
  endtask
  task automatic t_pd;
    conv_once(4'h8);
    chk(pd === 1'b1 && s == 0, "power down");
    conv_once(4'hB);
    chk(pd === 1'b0 && s > 40 && ch === 4'hB, "test select");
    $display("power down done");
  endtask
  task automatic t_pin;
    src = 2'h0; // Serial clock stands still outside frames
    pin_n = 0;
    repeat (40) @(negedge mclk); // Held low past the least sample time
    chk(samp === 1'b1 && ext === 1'b1, "pin sampling");
    pin_n = 1;
    repeat (3) @(negedge mclk);
    chk(conv === 1'b1 && samp === 1'b0, "pin conversion");
    repeat (80) @(negedge mclk);
    conv_once(4'hE);
    chk(dout === 12'h0A5C && dv === 1'b1, "buffered result");
    conv_once(4'h9);
    chk(ext === 1'b0, "leave extended");
    $display("pin done");
  endtask
  task automatic t_rep;
    mode = 2'h1;
    lvl = 2'h3;
    eoc_sel = 0;
    pin_n = 0;
    repeat (20) @(negedge mclk);
    chk(samp === 1'b0, "pin ignored");
    pin_n = 1;
    keep = 1; // Frame sync triggers from here on, select held low
    conv_once(4'h2);
    conv_once(4'h2);
    chk(cnt === 4'h2 && intr === 1'b1, "threshold");
    conv_once(4'h2);
    chk(cnt === 4'h1, "fifo cleared");
    $display("repeat done");
  endtask
  task automatic t_sweep;
    mode = 2'h2;
    conv_once(4'h5);
    chk(ch === 4'h1 && intr === 1'b1 && cnt === 4'h2, "sweep step");
    conv_once(4'h5);
    chk(s == 0 && cnt === 4'h2, "sweep held");
    conv_once(4'hE);
    chk(dout === 12'h0A5C && dv === 1'b1, "fifo read");
    conv_once(4'h5);
    chk(s > 40 && cnt === 4'h1, "sweep restart");
    $display("sweep done");
  endtask
  // Hang guard, far beyond the few thousand cycles of the tests
  initial
  begin
    #100000;
    err_total++;
    $display("mismatch %0t watchdog", $time);
    conclude();
  end
  initial
  begin
    {rst_n, run, osc, ref_int, long_s, mode, lvl, src, keep} = '0;
    {pin_n, eoc_sel} = 2'b11;
    code = 4'h0;
    repeat (8) @(negedge mclk);
    rst_n = 1;
    repeat (2) @(negedge mclk);
    t_normal();
    t_pd();
    t_pin();
    t_rep();
    t_sweep();
    conclude();
  end
endmodule
